// ---- verilog/bb_mau_defines.vh ----
// constants for the broadband attachment framing path
`ifndef BB_MAU_DEFINES_VH
`define BB_MAU_DEFINES_VH

// clock and bit timing
`define CLK_PERIOD_NS  10
`define BIT_TIME_NS    100
`define CLKS_PER_BIT   (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define HALF_BIT_CLKS  (`CLKS_PER_BIT / 2)
// manchester decode: edge this long after last mid-cell edge is mid-cell
`define MCH_MID_MIN    ((3 * `CLKS_PER_BIT) / 4)
// no mid-cell edge for this long ends the incoming frame
`define MCH_IDLE_CLKS  ((3 * `CLKS_PER_BIT) / 2)

// transmit framing, in bits
`define SYNC_BITS      6'h14
`define UMD_BITS       6'h02
`define POST_ONES      6'h16
`define POST_EXT       6'h04
`define SQE_START      6'h23
`define SQE_BITS       6'h1e

// scrambler, 1 + x^-18 + x^-23 part of the generator
`define SCR_LEN        23
`define SCR_TAP_A      17
`define SCR_TAP_B      22
`define SEED_RST       23'h000001

// receive framing
`define UMD_PAT        6'h14
`define RX_FILL_BITS   6'h2d
`define RX_DLY         22

`endif

// ---- verilog/mch_decoder.v ----
// manchester to nrz decoder for the incoming transmit data circuit
`include "bb_mau_defines.vh"

module mch_decoder (
   // clock and reset
   input  wire i_clk_sys,
   input  wire i_rst_b,
   // manchester line
   input  wire i_line,
   // decoded stream
   output reg  o_bit,
   output reg  o_stb,
   output reg  o_active
);

   reg       prev_r;
   reg [4:0] cnt_r;
   wire      edge_seen;
   wire      mid_cell;

   assign edge_seen = i_line ^ prev_r;
   // preamble has only mid-cell edges, so the first edge locks phase
   assign mid_cell  = edge_seen & (~o_active | (cnt_r >= `MCH_MID_MIN));

   // edge timing, bit value is the level after the mid-cell edge
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_r   <= 1'b1; // line idles high, so no false edge after reset
         cnt_r    <= 5'h00;
         o_bit    <= 1'b0;
         o_stb    <= 1'b0;
         o_active <= 1'b0;
      end else begin
         prev_r <= i_line;
         o_stb  <= mid_cell;
         if (mid_cell) begin
            o_bit    <= i_line;
            cnt_r    <= 5'h00;
            o_active <= 1'b1;
         end else begin
            if (cnt_r != 5'h1f)
               cnt_r <= cnt_r + 5'h01;
            if (cnt_r >= `MCH_IDLE_CLKS)
               o_active <= 1'b0;
         end
      end
   end

endmodule // mch_decoder

// ---- verilog/scr_core.v ----
// 23-stage scrambler or self-synchronising descrambler
`include "bb_mau_defines.vh"

module scr_core #(
   parameter MULTIPLY = 0
) (
   // clock and reset
   input  wire                  i_clk_sys,
   input  wire                  i_rst_b,
   // stream
   input  wire                  i_step,
   input  wire                  i_bit,
   output wire                  o_bit,
   // seed
   input  wire                  i_load,
   input  wire [`SCR_LEN-1:0]   i_seed
);

   reg [`SCR_LEN-1:0] sh_r;

   // feedback from outputs divides, feed-forward of inputs multiplies
   assign o_bit = i_bit ^ sh_r[`SCR_TAP_A] ^ sh_r[`SCR_TAP_B];

   // history register; descrambler never loads, so it needs no seed
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sh_r <= {`SCR_LEN{1'b0}};
      end else if (i_load && MULTIPLY == 0) begin
         sh_r <= i_seed;
      end else if (i_step) begin
         sh_r <= {sh_r[`SCR_LEN-2:0], (MULTIPLY != 0) ? i_bit : o_bit};
      end
   end

endmodule // scr_core

// ---- verilog/bb_mau_framing.v ----
// packet framing, scrambling and sqe test for a broadband attachment unit
`include "bb_mau_defines.vh"

module bb_mau_framing (
   // clock and reset
   input  wire i_clk_sys,
   input  wire i_rst_b,
   // station transmit data circuit, manchester
   input  wire i_aui_do,
   // rf modulator side
   output reg  o_mod_bit,
   output reg  o_mod_stb,
   output reg  o_mod_en,
   output reg  o_ce_burst,
   input  wire i_coll_det,
   // rf demodulator side
   input  wire i_rf_bit,
   input  wire i_rf_stb,
   input  wire i_rf_carrier,
   input  wire i_ce_detect,
   // station receive data circuit, manchester
   output reg  o_receive_data_circuit,
   output reg  o_rx_active
);

   // transmit states
   localparam TX_IDLE = 6'b000001;
   localparam TX_SYNC = 6'b000010;
   localparam TX_UMD  = 6'b000100;
   localparam TX_SCR  = 6'b001000;
   localparam TX_POST = 6'b010000;
   localparam TX_WAIT = 6'b100000;
   // receive states
   localparam RX_IDLE = 3'b001;
   localparam RX_FILL = 3'b010;
   localparam RX_DATA = 3'b100;

   // decoder and bit timing
   wire               dec_bit;
   wire               dec_stb;
   wire               dec_active;
   reg  [3:0]         div_r;
   wire               bit_tick;
   reg  [`SCR_LEN-1:0] seed_r;

   // transmit control
   reg  [5:0] tx_st_r;
   reg  [5:0] tx_st_nxt;
   reg  [5:0] tx_cnt_r;
   reg  [5:0] tx_cnt_nxt;
   reg        sqe_on_r;
   reg        sqe_on_nxt;
   reg        coll_seen_r;
   reg        emit;
   reg        ebit;
   reg        scr_step;
   reg        seed_load;
   reg        en_nxt;
   wire       scr_bit;

   // receive control
   reg  [2:0]  rx_st_r;
   reg  [5:0]  rx_cnt_r;
   reg         rf_prev_r;
   reg  [22:0] hist_r;
   reg  [`RX_DLY-1:0] dly_r;
   wire        rd;
   wire        descr_bit;
   wire        umd_seen;
   wire        post_det;
   reg         ld_r;
   reg         ld_bit_r;
   reg         enc_bit_r;
   reg  [3:0]  enc_ph_r;

   mch_decoder u_dec (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_line    (i_aui_do),
      .o_bit     (dec_bit),
      .o_stb     (dec_stb),
      .o_active  (dec_active)
   );

   scr_core #(.MULTIPLY(0)) u_scr (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_step    (scr_step),
      .i_bit     (dec_bit),
      .o_bit     (scr_bit),
      .i_load    (seed_load),
      .i_seed    (seed_r)
   );

   // free bit clock and seed source; x^23 + x^18 + 1 never reaches zero
   assign bit_tick = (div_r == (`CLKS_PER_BIT - 1));
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_r  <= 4'h0;
         seed_r <= `SEED_RST;
      end else begin
         div_r <= bit_tick ? 4'h0 : div_r + 4'h1;
         if (bit_tick)
            seed_r <= {seed_r[`SCR_LEN-2:0], seed_r[22] ^ seed_r[17]};
      end
   end

   // transmit framing sequence; incoming bits before the first zero drop
   always @* begin
      tx_st_nxt  = tx_st_r;
      tx_cnt_nxt = tx_cnt_r;
      sqe_on_nxt = sqe_on_r;
      en_nxt     = o_mod_en;
      emit       = 1'b0;
      ebit       = 1'b0;
      scr_step   = 1'b0;
      seed_load  = 1'b0;
      if (tx_st_r == TX_IDLE && !sqe_on_r) begin
         if (dec_stb && !dec_bit) begin
            emit       = 1'b1;
            ebit       = 1'b0;
            seed_load  = 1'b1;
            en_nxt     = 1'b1;
            tx_cnt_nxt = 6'h01;
            tx_st_nxt  = TX_SYNC;
         end
      end else if (sqe_on_r) begin
         // burst length counted on the free bit clock
         if (bit_tick) begin
            tx_cnt_nxt = tx_cnt_r + 6'h01;
            if (tx_cnt_r == `SQE_BITS - 6'h01) begin
               sqe_on_nxt = 1'b0;
               tx_cnt_nxt = 6'h00;
            end
         end
      end else begin
         case (tx_st_r)
            TX_SYNC: begin
               if (dec_stb) begin
                  emit       = 1'b1;
                  ebit       = tx_cnt_r[0];
                  tx_cnt_nxt = tx_cnt_r + 6'h01;
                  if (tx_cnt_r == `SYNC_BITS - 6'h01) begin
                     tx_cnt_nxt = 6'h00;
                     tx_st_nxt  = TX_UMD;
                  end
               end else if (!dec_active) begin
                  tx_cnt_nxt = 6'h00;
                  tx_st_nxt  = TX_POST;
               end
            end
            TX_UMD: begin
               if (dec_stb) begin
                  emit       = 1'b1;
                  ebit       = 1'b0;
                  tx_cnt_nxt = tx_cnt_r + 6'h01;
                  if (tx_cnt_r == `UMD_BITS - 6'h01)
                     tx_st_nxt = TX_SCR;
               end else if (!dec_active) begin
                  tx_cnt_nxt = 6'h00;
                  tx_st_nxt  = TX_POST;
               end
            end
            TX_SCR: begin
               if (dec_stb) begin
                  emit     = 1'b1;
                  ebit     = scr_bit;
                  scr_step = 1'b1;
               end else if (!dec_active) begin
                  tx_cnt_nxt = 6'h00;
                  tx_st_nxt  = TX_POST;
               end
            end
            TX_POST: begin
               if (bit_tick) begin
                  tx_cnt_nxt = tx_cnt_r + 6'h01;
                  if (tx_cnt_r == `POST_ONES + `POST_EXT + 6'h01) begin
                     // carrier drops a bit later, so the last one goes out whole
                     en_nxt    = 1'b0;
                     tx_st_nxt = TX_WAIT;
                  end else begin
                     emit = 1'b1;
                     ebit = (tx_cnt_r != 6'h00);
                  end
               end
            end
            TX_WAIT: begin
               // data carrier is already off, so the burst never overlaps it
               if (bit_tick) begin
                  tx_cnt_nxt = tx_cnt_r + 6'h01;
                  if (tx_cnt_r == `SQE_START - 6'h01) begin
                     tx_cnt_nxt = 6'h00;
                     tx_st_nxt  = TX_IDLE;
                     sqe_on_nxt = ~coll_seen_r;
                  end
               end
            end
            default: begin
               tx_st_nxt  = TX_IDLE;
               tx_cnt_nxt = 6'h00;
            end
         endcase
      end
   end

   // transmit registers; inversion then differential encoding of every bit
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_st_r     <= TX_IDLE;
         tx_cnt_r    <= 6'h00;
         sqe_on_r    <= 1'b0;
         coll_seen_r <= 1'b0;
         o_mod_bit   <= 1'b0;
         o_mod_stb   <= 1'b0;
         o_mod_en    <= 1'b0;
         o_ce_burst  <= 1'b0;
      end else begin
         tx_st_r    <= tx_st_nxt;
         tx_cnt_r   <= tx_cnt_nxt;
         sqe_on_r   <= sqe_on_nxt;
         o_ce_burst <= sqe_on_nxt;
         o_mod_en   <= en_nxt;
         o_mod_stb  <= emit;
         if (emit)
            o_mod_bit <= o_mod_bit ^ ~ebit;
         if (tx_st_r == TX_IDLE)
            coll_seen_r <= 1'b0;
         else if (i_coll_det)
            coll_seen_r <= 1'b1;
      end
   end

   // restored stream: differential decode, invert, force one without carrier
   assign rd = i_rf_carrier ? ~(i_rf_bit ^ rf_prev_r) : 1'b1;

   scr_core #(.MULTIPLY(1)) u_dscr (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_step    (i_rf_stb),
      .i_bit     (rd),
      .o_bit     (descr_bit),
      .i_load    (1'b0),
      .i_seed    ({`SCR_LEN{1'b0}})
   );

   // delimiter: end of alternating sync followed by two zeros
   assign umd_seen = ({hist_r[4:0], rd} == `UMD_PAT);
   // postamble: a zero followed by twenty-two ones, current bit included;
   // seen as the postamble zero leaves the delay line, so it never goes out
   assign post_det = ({hist_r[21:0], rd} == {1'b0, {22{1'b1}}});

   // receive framing; delay line lets fill cover bits already gone by
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_st_r   <= RX_IDLE;
         rx_cnt_r  <= 6'h00;
         rf_prev_r <= 1'b0;
         hist_r    <= 23'h7fffff;
         dly_r     <= {`RX_DLY{1'b0}};
         ld_r      <= 1'b0;
         ld_bit_r  <= 1'b0;
      end else begin
         ld_r <= 1'b0;
         if (i_rf_stb) begin
            rf_prev_r <= i_rf_bit;
            hist_r    <= {hist_r[21:0], rd};
            dly_r     <= {dly_r[`RX_DLY-2:0], descr_bit};
            case (rx_st_r)
               RX_IDLE: begin
                  if (i_rf_carrier && umd_seen) begin
                     rx_cnt_r <= 6'h00;
                     rx_st_r  <= RX_FILL;
                  end
               end
               RX_FILL: begin
                  ld_r     <= 1'b1;
                  ld_bit_r <= rx_cnt_r[0];
                  rx_cnt_r <= rx_cnt_r + 6'h01;
                  if (rx_cnt_r == `RX_FILL_BITS - 6'h01)
                     rx_st_r <= RX_DATA;
               end
               RX_DATA: begin
                  if (post_det || !i_rf_carrier) begin
                     rx_st_r <= RX_IDLE;
                  end else begin
                     ld_r     <= 1'b1;
                     ld_bit_r <= dly_r[`RX_DLY-1];
                  end
               end
               default: rx_st_r <= RX_IDLE;
            endcase
         end
      end
   end

   // manchester encoder; a cell always completes, even mid-collision
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enc_bit_r              <= 1'b0;
         enc_ph_r               <= 4'h0;
         o_rx_active            <= 1'b0;
         o_receive_data_circuit <= 1'b1;
      end else begin
         if (ld_r) begin
            enc_bit_r   <= ld_bit_r;
            enc_ph_r    <= 4'h0;
            o_rx_active <= 1'b1;
         end else if (enc_ph_r == (`CLKS_PER_BIT - 1)) begin
            o_rx_active <= 1'b0;
         end else begin
            enc_ph_r <= enc_ph_r + 4'h1;
         end
         if (ld_r)
            o_receive_data_circuit <= ~ld_bit_r;
         else if (!o_rx_active || enc_ph_r == (`CLKS_PER_BIT - 1))
            o_receive_data_circuit <= 1'b1;
         else if (enc_ph_r >= (`HALF_BIT_CLKS - 1))
            o_receive_data_circuit <= enc_bit_r;
         else
            o_receive_data_circuit <= ~enc_bit_r;
      end
   end

   // collision detect from the demodulator is left unused
   wire unused_ce = i_ce_detect;

endmodule // bb_mau_framing

// ---- tb/bb_mau_framing_props.sv ----
// assertion checker for the broadband framing block
module bb_mau_framing_props (
   // clock and reset
   input logic i_clk_sys,
   input logic i_rst_b,
   // modulator side
   input logic o_mod_bit,
   input logic o_mod_stb,
   input logic o_mod_en,
   input logic o_ce_burst,
   // receive side
   input logic i_rf_carrier,
   input logic o_receive_data_circuit,
   input logic o_rx_active
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] burst_cnt_r;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);

   // burst length, read back on the cycle it ends
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) burst_cnt_r <= 9'h000;
      else burst_cnt_r <= o_ce_burst ? burst_cnt_r + 9'h001 : 9'h000;
   end

   AST_STB_GAP: assert property (o_mod_stb |=> !o_mod_stb [*4])
      else $error("modulator strobes too close");
   AST_BIT_ON_STB: assert property ($changed(o_mod_bit) |-> o_mod_stb)
      else $error("modulator bit moved without strobe");
   AST_STB_IN_CARRIER: assert property (o_mod_stb |-> o_mod_en)
      else $error("bit sent with carrier off");
   AST_BURST_APART: assert property (!(o_ce_burst && o_mod_en))
      else $error("burst overlaps data carrier");
   AST_BURST_LEN: assert property ($fell(o_ce_burst) |->
      (burst_cnt_r >= 9'h122 && burst_cnt_r <= 9'h136))
      else $error("burst length out of range");
   AST_RX_IDLE_HIGH: assert property (!o_rx_active |-> o_receive_data_circuit)
      else $error("receive line not idle high");
   AST_RX_MID_EDGE: assert property ($rose(o_rx_active) |=>
      $stable(o_receive_data_circuit) [*4] ##1 $changed(o_receive_data_circuit))
      else $error("receive cell lacks mid-cell edge");
   AST_RX_CARRIER_END: assert property ($fell(i_rf_carrier) |-> ##[0:12] !o_rx_active)
      else $error("receive output ran on after carrier loss");
   AST_RESET_QUIET: assert property ($rose(i_rst_b) |->
      !o_mod_en && !o_ce_burst && o_receive_data_circuit && !o_rx_active)
      else $error("outputs not quiet after reset");

   // main scenarios reached
   cover property ($rose(o_ce_burst));
   cover property ($rose(o_rx_active));
   cover property (o_mod_stb && o_mod_en);
endmodule // bb_mau_framing_props

bind bb_mau_framing bb_mau_framing_props i_props (
   .i_clk_sys             (i_clk_sys),
   .i_rst_b               (i_rst_b),
   .o_mod_bit             (o_mod_bit),
   .o_mod_stb             (o_mod_stb),
   .o_mod_en              (o_mod_en),
   .o_ce_burst            (o_ce_burst),
   .i_rf_carrier          (i_rf_carrier),
   .o_receive_data_circuit(o_receive_data_circuit),
   .o_rx_active           (o_rx_active)
);

// ---- tb/station_modem_model.sv ----
// station manchester source and rf demodulator model
module station_modem_model (
   // clock
   input  logic i_clk_sys,
   // toward the block
   output logic o_aui_do,
   output logic o_rf_bit,
   output logic o_rf_stb,
   output logic o_rf_carrier
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rf_prev;

   // idle line high so the first cell opens on a mid-cell edge
   initial begin
      o_aui_do = 1'b1;
      o_rf_bit = 1'b1;
      o_rf_stb = 1'b0;
      o_rf_carrier = 1'b0;
      rf_prev = 1'b1;
   end

   // one ten-clock manchester cell, inverse half first
   task send_cell(input logic b);
      @(posedge i_clk_sys) o_aui_do <= ~b;
      repeat (5) @(posedge i_clk_sys);
      o_aui_do <= b;
      repeat (4) @(posedge i_clk_sys);
   endtask

   // return to idle; too soon after mid-cell to count as a bit
   task line_idle;
      @(posedge i_clk_sys) o_aui_do <= 1'b1;
   endtask

   // restored bit r sent differentially; line is junk off the strobe
   task send_rf(input logic r, input logic car);
      @(posedge i_clk_sys);
      rf_prev = rf_prev ^ ~r;
      o_rf_bit <= rf_prev;
      o_rf_stb <= 1'b1;
      o_rf_carrier <= car;
      @(posedge i_clk_sys);
      o_rf_stb <= 1'b0;
      o_rf_bit <= ~rf_prev;
      repeat (8) @(posedge i_clk_sys);
   endtask
endmodule // station_modem_model

// ---- tb/bb_mau_framing_tb.sv ----
// self-checking bench for the broadband framing block
module bb_mau_framing_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int pre; logic [15:0] data; logic coll; logic sqe;} row_t;
   row_t rows[3] = '{'{61, 16'hc3a5, 1'b0, 1'b1}, '{47, 16'h0ff0, 1'b0, 1'b1},
                     '{47, 16'h0ff0, 1'b1, 1'b0}};
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_coll_det = 1'b0;
   logic i_ce_detect = 1'b0;
   wire  i_aui_do, i_rf_bit, i_rf_stb, i_rf_carrier;
   wire  o_mod_bit, o_mod_stb, o_mod_en, o_ce_burst, o_receive_data_circuit, o_rx_active;
   int   n_errors = 0;
   int   tests_run = 0;
   int   clk_n = 0;
   int   rx_ph = 0;
   int   t_rise, t_fall, r, i, s;
   int   tq[$];
   logic txq[$], rxq[$], inq[$];
   logic tx_prev = 1'b0;
   logic ce_prev = 1'b0;
   logic rx_h, b;
   logic [22:0] hist, scr[3];
   logic [23:0] tail;
   logic [39:0] pay = 40'h9e37_51c2_a4;

   always #5 i_clk_sys = ~i_clk_sys;

   bb_mau_framing i_bb_mau_framing (
      .i_clk_sys             (i_clk_sys),
      .i_rst_b               (i_rst_b),
      .i_aui_do              (i_aui_do),
      .o_mod_bit             (o_mod_bit),
      .o_mod_stb             (o_mod_stb),
      .o_mod_en              (o_mod_en),
      .o_ce_burst            (o_ce_burst),
      .i_coll_det            (i_coll_det),
      .i_rf_bit              (i_rf_bit),
      .i_rf_stb              (i_rf_stb),
      .i_rf_carrier          (i_rf_carrier),
      .i_ce_detect           (i_ce_detect),
      .o_receive_data_circuit(o_receive_data_circuit),
      .o_rx_active           (o_rx_active)
   );

   station_modem_model i_station_modem_model (
      .i_clk_sys   (i_clk_sys),
      .o_aui_do    (i_aui_do),
      .o_rf_bit    (i_rf_bit),
      .o_rf_stb    (i_rf_stb),
      .o_rf_carrier(i_rf_carrier)
   );

   task chk(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task chk_n(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         n_errors++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // bounded wait for carrier or receive activity to drop
   task wait_low(input bit rx);
      int k;
      for (k = 0; k < 3000; k++) begin
         @(negedge i_clk_sys);
         if ((rx ? o_rx_active : o_mod_en) === 1'b0) return;
      end
      n_errors++;
      $display("mismatch wait_low expected 0 seen 1");
      tally_and_finish;
   endtask

   // two-cycle reset, outputs checked while held
   task reset_dut;
      @(posedge i_clk_sys) i_rst_b <= 1'b0;
      @(negedge i_clk_sys);
      chk("rst_en", 1'b0, o_mod_en);
      chk("rst_stb", 1'b0, o_mod_stb);
      chk("rst_burst", 1'b0, o_ce_burst);
      chk("rst_rx", 1'b1, o_receive_data_circuit);
      chk("rst_rxact", 1'b0, o_rx_active);
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
   endtask

   // undo the differential coding and sample receive cells mid-half
   always @(posedge i_clk_sys) begin
      clk_n++;
      if (o_mod_stb === 1'b1) begin
         txq.push_back(~(o_mod_bit ^ tx_prev));
         tx_prev = o_mod_bit;
         tq.push_back(clk_n);
      end
      if (o_ce_burst === 1'b1 && !ce_prev) t_rise = clk_n;
      if (o_ce_burst !== 1'b1 && ce_prev) t_fall = clk_n;
      ce_prev = (o_ce_burst === 1'b1);
      rx_ph = (o_rx_active === 1'b1) ? rx_ph + 1 : 0;
      if (rx_ph % 10 == 3) rx_h = o_receive_data_circuit;
      if (rx_ph % 10 == 8) begin
         chk("rx_half", ~rx_h, o_receive_data_circuit);
         rxq.push_back(o_receive_data_circuit);
      end
   end

   initial begin
      reset_dut();
      // transmit rows: preamble ends in zero, then frame delimiter and data
      for (r = 0; r < 3; r++) begin
         inq.delete();
         txq.delete();
         tq.delete();
         t_rise = 0;
         tail = {8'hab, rows[r].data};
         for (i = 0; i < rows[r].pre; i++) inq.push_back(logic'((rows[r].pre - 1 - i) % 2));
         for (i = 23; i >= 0; i--) inq.push_back(tail[i]);
         @(posedge i_clk_sys) i_coll_det <= rows[r].coll;
         foreach (inq[i]) i_station_modem_model.send_cell(inq[i]);
         i_station_modem_model.line_idle();
         wait_low(0);
         @(posedge i_clk_sys) i_coll_det <= 1'b0;
         repeat (450) @(posedge i_clk_sys);
         s = inq.size() - 22;
         chk_n("tx_len", s + 49, txq.size());
         for (i = 0; i < 22; i++) chk("sync", i < 20 ? logic'(i % 2) : 1'b0, txq[i]);
         for (i = 45; i < s + 22; i++) chk("descr", inq[i], txq[i] ^ txq[i-18] ^ txq[i-23]);
         for (i = 0; i < 27; i++) chk("post", i > 0, txq[s + 22 + i]);
         for (i = 0; i < 23; i++) scr[r][i] = txq[22 + i];
         chk("sqe", rows[r].sqe, t_rise > 0);
         if (rows[r].sqe) begin
            chk("sqe_delay", 1'b1, (t_rise - tq[s + 22]) inside {[320:380]});
            chk("sqe_len", 1'b1, (t_fall - t_rise) inside {[290:310]});
         end
      end
      chk("seed_fresh", 1'b1, scr[1] !== scr[2]);
      // sync and delimiter with no carrier must open nothing
      for (i = 0; i < 22; i++) i_station_modem_model.send_rf(i < 20 ? logic'(i % 2) : 1'b0, 1'b0);
      repeat (30) @(posedge i_clk_sys);
      chk_n("rx_nocar", 0, rxq.size());
      // real frame, scrambled from a seed the receiver never sees
      hist = 23'h05a5a5;
      for (i = 0; i < 22; i++) i_station_modem_model.send_rf(i < 20 ? logic'(i % 2) : 1'b0, 1'b1);
      for (i = 0; i < 40; i++) begin
         b = pay[39 - i] ^ hist[17] ^ hist[22];
         hist = {hist[21:0], b};
         i_station_modem_model.send_rf(b, 1'b1);
      end
      for (i = 0; i < 30; i++) i_station_modem_model.send_rf(i > 0, i < 23);
      wait_low(1);
      chk_n("rx_len", 62, rxq.size());
      for (i = 0; i < 62; i++) chk("rx_bit", i < 45 ? logic'(i % 2) : pay[61 - i], rxq[i]);
      // abort a packet in scrambled data, past sync and delimiter, with a second reset
      for (i = 0; i < 30; i++) i_station_modem_model.send_cell(logic'(i % 2));
      @(negedge i_clk_sys);
      chk("en_mid", 1'b1, o_mod_en);
      reset_dut();
      tally_and_finish;
   end
endmodule // bb_mau_framing_tb
